// ### rtl/spdif_tx_pkg.sv
// constants, register map and field layouts of the s/pdif transmitter registers
// assumes an apb master with 32-bit data and word addressing of each register
package spdif_tx_pkg;

	// ------------------------------------------------------------
	// register map: printed offsets are indices, byte address = 4 x index
	// ------------------------------------------------------------
	localparam int            ADDR_W               = 18;
	localparam logic [15:0]   IDX_LEFT_LOW         = 16'hfd02;
	localparam logic [15:0]   IDX_LEFT_HIGH        = 16'hfd03;
	localparam logic [15:0]   IDX_RIGHT_LOW        = 16'hfd04;
	localparam logic [15:0]   IDX_RIGHT_HIGH       = 16'hfd05;
	localparam logic [15:0]   IDX_CS_WORD0         = 16'hfd08;
	localparam logic [15:0]   IDX_CS_WORD1         = 16'hfd09;
	localparam logic [15:0]   IDX_CS_WORD2         = 16'hfd0a;
	localparam logic [15:0]   IDX_TX_CONFIG        = 16'hfd0b;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0]   RST_CS_WORD          = 16'h0000;
	localparam logic [15:0]   RST_TX_CONFIG        = 16'h0040;
	localparam logic [23:0]   RST_SAMPLE           = 24'h000000;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int            CS1_TOP_LSB          = 14;
	localparam logic [1:0]    CS1_TOP_VALUE        = 2'h0;
	localparam int            CS2_NEW_WORD_BIT     = 13;
	localparam logic [15:0]   CS2_WRITE_MASK       = 16'h1fff;
	localparam int            CS_STATUS_BITS       = 40;

	// ------------------------------------------------------------
	// line timing: 64 half-cells per subframe, 192 frames per block
	// ------------------------------------------------------------
	localparam logic [5:0]    HALF_LAST            = 6'h3f;
	localparam logic [4:0]    SLOT_FIRST_DATA      = 5'h04;
	localparam logic [4:0]    SLOT_PARITY          = 5'h1f;
	localparam logic [7:0]    FRAME_LAST           = 8'hbf;
	localparam logic [7:0]    PRE_BLOCK            = 8'he8;
	localparam logic [7:0]    PRE_LEFT             = 8'he2;
	localparam logic [7:0]    PRE_RIGHT            = 8'he4;

	typedef struct packed {
		logic [13:0] tx_clock_divider;
		logic        tx_interrupt_enable;
		logic        send_words_flag;
	} tx_config_t;

	typedef struct packed {
		logic [1:0] unused;
		logic       new_word_request;
		logic       transmit_enable;
		logic       right_user_bit;
		logic       right_validity_bit;
		logic       left_user_bit;
		logic       left_validity_bit;
		logic [3:0] original_rate_code;
		logic [2:0] word_length_code;
		logic       max_word_length_flag;
	} chan_status2_t;

endpackage : spdif_tx_pkg

// ### rtl/spdif_transmit_regs.sv
// apb register block and biphase-mark line generator of the s/pdif transmitter
// assumes pclk at 125 mhz, one clock domain and a receiver on spdif_out_r
//
// The APB slave port was left to the implementer.
module spdif_transmit_regs
	import spdif_tx_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   spdif_out_r,
	output logic                   tx_irq_r
);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [7:0]     left_low_r;
	logic [15:0]    left_high_r;
	logic [7:0]     right_low_r;
	logic [15:0]    right_high_r;
	logic [15:0]    cs_word0_r;
	logic [15:0]    cs_word1_r;
	chan_status2_t  cs_word2_r;
	tx_config_t     config_r;
	logic           new_word_r;

	// line state
	logic [13:0]    div_cnt_r;
	logic [5:0]     half_r;
	logic           sub_r;
	logic [7:0]     frame_r;
	logic           pre_lvl_r;
	logic [23:0]    hold_left_r;
	logic [23:0]    hold_right_r;

	logic           access;
	logic           wr_en;
	logic           tick;
	logic           capture;
	logic [4:0]     slot;
	logic [CS_STATUS_BITS-1:0] cs_vec;
	logic           cs_bit;
	logic [26:0]    sub_word;
	logic           data_bit;
	logic [7:0]     pre_pat;
	logic           pre_lvl;
	logic           line_nxt;

	// matches a byte address against a register index
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a[ADDR_W-1:2] == idx);
	endfunction : hit

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, IDX_LEFT_LOW) | hit(a, IDX_LEFT_HIGH) | hit(a, IDX_RIGHT_LOW)
			| hit(a, IDX_RIGHT_HIGH) | hit(a, IDX_CS_WORD0) | hit(a, IDX_CS_WORD1)
			| hit(a, IDX_CS_WORD2) | hit(a, IDX_TX_CONFIG);
	endfunction : mapped

	// ------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ------------------------------------------------------------
	assign access = psel & penable & ~pready;
	assign wr_en  = psel & penable & pready & pwrite & ~pslverr;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= access;
			pslverr <= access & ~mapped(paddr);
		end
	end

	// write-only sample registers read back as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (access & ~pwrite)
		begin
			if (hit(paddr, IDX_CS_WORD0))
				prdata <= {16'h0000, cs_word0_r};
			else if (hit(paddr, IDX_CS_WORD1))
				prdata <= {16'h0000, cs_word1_r};
			else if (hit(paddr, IDX_CS_WORD2))
				prdata <= {16'h0000, cs_word2_r};
			else if (hit(paddr, IDX_TX_CONFIG))
				prdata <= {16'h0000, config_r};
			else
				prdata <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// sample registers
	// ------------------------------------------------------------
	// split sample words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_low_r   <= RST_SAMPLE[7:0];
			left_high_r  <= RST_SAMPLE[23:8];
			right_low_r  <= RST_SAMPLE[7:0];
			right_high_r <= RST_SAMPLE[23:8];
		end
		else if (wr_en)
		begin
			if (hit(paddr, IDX_LEFT_LOW))
				left_low_r <= pwdata[7:0];
			if (hit(paddr, IDX_LEFT_HIGH))
				left_high_r <= pwdata[15:0];
			if (hit(paddr, IDX_RIGHT_LOW))
				right_low_r <= pwdata[7:0];
			if (hit(paddr, IDX_RIGHT_HIGH))
				right_high_r <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// channel status and configuration
	// ------------------------------------------------------------
	// word0 fields
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cs_word0_r <= RST_CS_WORD;
		else if (wr_en & hit(paddr, IDX_CS_WORD0))
			cs_word0_r <= pwdata[15:0];
	end

	// top two bits held at zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cs_word1_r <= RST_CS_WORD;
		else if (wr_en & hit(paddr, IDX_CS_WORD1))
			cs_word1_r <= {CS1_TOP_VALUE, pwdata[CS1_TOP_LSB-1:0]};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cs_word2_r <= chan_status2_t'(RST_CS_WORD);
		else if (wr_en & hit(paddr, IDX_CS_WORD2))
			// read-only request bit must not drop during a software write
			cs_word2_r <= chan_status2_t'((pwdata[15:0] & CS2_WRITE_MASK)
				| {2'b00, new_word_r, 13'h0000});
		else
			cs_word2_r.new_word_request <= new_word_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			config_r <= tx_config_t'(RST_TX_CONFIG);
		else if (wr_en & hit(paddr, IDX_TX_CONFIG))
			config_r <= tx_config_t'(pwdata[15:0]);
	end

	// set wins over clear by left high write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			new_word_r <= 1'b0;
		else if (capture)
			new_word_r <= 1'b1;
		else if (wr_en & hit(paddr, IDX_LEFT_HIGH))
			new_word_r <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_irq_r <= 1'b0;
		else
			tx_irq_r <= new_word_r & config_r.tx_interrupt_enable;
	end

	// ------------------------------------------------------------
	// half-cell clock divider
	// ------------------------------------------------------------
	// divider ticks, zero stalls the line
	assign tick = cs_word2_r.transmit_enable && (config_r.tx_clock_divider != 14'h0000)
		&& (div_cnt_r >= config_r.tx_clock_divider - 14'h0001);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_r <= 14'h0000;
		else if (!cs_word2_r.transmit_enable || tick)
			div_cnt_r <= 14'h0000;
		else
			div_cnt_r <= div_cnt_r + 14'h0001;
	end

	// ------------------------------------------------------------
	// frame position counters
	// ------------------------------------------------------------
	assign capture = tick & sub_r & (half_r == HALF_LAST);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			half_r  <= 6'h00;
			sub_r   <= 1'b0;
			frame_r <= 8'h00;
		end
		else if (!cs_word2_r.transmit_enable)
		begin
			half_r  <= 6'h00;
			sub_r   <= 1'b0;
			frame_r <= 8'h00;
		end
		else if (tick)
		begin
			half_r <= half_r + 6'h01;
			if (half_r == HALF_LAST)
			begin
				sub_r <= ~sub_r;
				if (sub_r)
					frame_r <= (frame_r == FRAME_LAST) ? 8'h00 : frame_r + 8'h01;
			end
		end
	end

	// hold samples for the whole next frame
	// zero payload when send flag clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_left_r  <= RST_SAMPLE;
			hold_right_r <= RST_SAMPLE;
		end
		else if (!cs_word2_r.transmit_enable)
		begin
			hold_left_r  <= RST_SAMPLE;
			hold_right_r <= RST_SAMPLE;
		end
		else if (capture)
		begin
			hold_left_r  <= config_r.send_words_flag ? {left_high_r, left_low_r} : RST_SAMPLE;
			hold_right_r <= config_r.send_words_flag ? {right_high_r, right_low_r} : RST_SAMPLE;
		end
	end

	// ------------------------------------------------------------
	// subframe assembly and biphase-mark coder
	// ------------------------------------------------------------
	// shared status vector
	assign cs_vec  = {cs_word2_r.original_rate_code, cs_word2_r.word_length_code,
		cs_word2_r.max_word_length_flag, cs_word1_r, cs_word0_r};
	assign cs_bit  = (frame_r < 8'(CS_STATUS_BITS)) ? cs_vec[frame_r[5:0]] : 1'b0;
	assign slot    = half_r[5:1];

	assign sub_word = sub_r
		? {cs_bit, cs_word2_r.right_user_bit, cs_word2_r.right_validity_bit, hold_right_r}
		: {cs_bit, cs_word2_r.left_user_bit, cs_word2_r.left_validity_bit, hold_left_r};

	// even parity over the data slots
	always_comb
	begin
		if (slot == SLOT_PARITY)
			data_bit = ^sub_word;
		else if (slot >= SLOT_FIRST_DATA)
			data_bit = sub_word[slot - SLOT_FIRST_DATA];
		else
			data_bit = 1'b0;
	end

	always_comb
	begin
		if (sub_r)
			pre_pat = PRE_RIGHT;
		else if (frame_r == 8'h00)
			pre_pat = PRE_BLOCK;
		else
			pre_pat = PRE_LEFT;
	end

	// preamble polarity follows the level left by the previous subframe
	assign pre_lvl = (half_r == 6'h00) ? spdif_out_r : pre_lvl_r;

	always_comb
	begin
		if (slot < SLOT_FIRST_DATA)
			line_nxt = pre_pat[3'd7 - half_r[2:0]] ^ pre_lvl;
		else if (!half_r[0])
			line_nxt = ~spdif_out_r;
		else
			line_nxt = data_bit ? ~spdif_out_r : spdif_out_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			spdif_out_r <= 1'b0;
			pre_lvl_r   <= 1'b0;
		end
		else if (!cs_word2_r.transmit_enable)
		begin
			spdif_out_r <= 1'b0;
			pre_lvl_r   <= 1'b0;
		end
		else if (tick)
		begin
			spdif_out_r <= line_nxt;
			if (half_r == 6'h00)
				pre_lvl_r <= spdif_out_r;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence left_high_write;
		wr_en && hit(paddr, IDX_LEFT_HIGH) && !capture;
	endsequence

	sequence data_slot_start;
		tick && (slot >= SLOT_FIRST_DATA) && !half_r[0];
	endsequence

	AST_NWR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		left_high_write |=> !new_word_r ##1 !cs_word2_r.new_word_request)
		else $error("request flag not cleared by left high write");

	AST_NWR_SET: assert property (@(posedge pclk) disable iff (!presetn)
		capture |=> new_word_r ##1 cs_word2_r.new_word_request)
		else $error("request flag not set at frame boundary");

	AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		tx_irq_r == $past(new_word_r && config_r.tx_interrupt_enable))
		else $error("interrupt does not follow gated request");

	AST_NWR_NO_IE: assert property (@(posedge pclk) disable iff (!presetn)
		capture && !config_r.tx_interrupt_enable |=> new_word_r && !tx_irq_r)
		else $error("request flag depends on interrupt enable");

	AST_IDLE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		!cs_word2_r.transmit_enable |=> !spdif_out_r && (half_r == 6'h00))
		else $error("line active while transmitter disabled");

	AST_CS1_TOP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit(paddr, IDX_CS_WORD1) |=> cs_word1_r[15:14] == CS1_TOP_VALUE)
		else $error("status word1 top bits not zero");

	AST_ZERO_PAYLOAD: assert property (@(posedge pclk) disable iff (!presetn)
		capture && !config_r.send_words_flag |=> hold_left_r == RST_SAMPLE
			&& hold_right_r == RST_SAMPLE)
		else $error("payload not zero with send flag clear");

	AST_SAMPLE_JOIN: assert property (@(posedge pclk) disable iff (!presetn)
		capture && config_r.send_words_flag |=> hold_left_r == $past({left_high_r, left_low_r}))
		else $error("left sample not joined from high and low");

	AST_HOLD_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
		!capture && cs_word2_r.transmit_enable |=> $stable(hold_left_r) && $stable(hold_right_r))
		else $error("held sample changed inside a frame");

	AST_CELL_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		data_slot_start |=> spdif_out_r != $past(spdif_out_r))
		else $error("no transition at data cell start");

	AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not a single cycle");

endmodule : spdif_transmit_regs

// ### verification/spdif_line_receiver.sv
// receiver model on the serial line of the s/pdif transmitter
// assumes divider 1, so one half-cell lasts one pclk and is sampled on the rising edge
module spdif_line_receiver
	import spdif_tx_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        line,
	output logic             rx_stb,
	output logic [1:0]       rx_kind,
	output logic [27:0]      rx_word
);
	logic [63:0] hist_r;
	logic [63:0] hist_nxt;
	logic [1:0]  last_r;
	logic [1:0]  kind_nxt;
	logic [27:0] word_nxt;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// preamble and biphase decode
	// three equal half-cells occur only in preambles, so data cannot fake a lock
	always_comb
	begin
		hist_nxt = {hist_r[62:0], line};
		kind_nxt = 2'h3;
		if (hist_nxt[7:0] == PRE_BLOCK || hist_nxt[7:0] == ~PRE_BLOCK)
			kind_nxt = 2'h0;
		if (hist_nxt[7:0] == PRE_LEFT || hist_nxt[7:0] == ~PRE_LEFT)
			kind_nxt = 2'h1;
		if (hist_nxt[7:0] == PRE_RIGHT || hist_nxt[7:0] == ~PRE_RIGHT)
			kind_nxt = 2'h2;
		for (int i = 0; i < 28; i++)
			word_nxt[i] = hist_nxt[63-2*i] ^ hist_nxt[62-2*i];
	end

	// a subframe is only complete once the next preamble shows up
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hist_r  <= 64'h0;
			last_r  <= 2'h3;
			rx_stb  <= 1'b0;
			rx_kind <= 2'h3;
			rx_word <= 28'h0;
		end
		else
		begin
			hist_r  <= hist_nxt;
			rx_stb  <= kind_nxt != 2'h3 && last_r != 2'h3;
			rx_kind <= last_r;
			rx_word <= word_nxt;
			if (kind_nxt != 2'h3)
				last_r <= kind_nxt;
		end
	end
endmodule : spdif_line_receiver

// ### verification/test_spdif_transmit_regs.sv
// self-checking bench of the s/pdif transmitter registers
// assumes the line receiver model and apb with one wait state
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH at %0t got %h expected %h", $time, (g), (e)); end end
module test_spdif_transmit_regs
	import spdif_tx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [23:0] LS  = 24'h9a7c31;
	localparam logic [23:0] RS  = 24'h5e2b00;
	localparam logic [39:0] CSV = {8'ha5, 16'h35c3, 16'hc3a6};
	logic              pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, spdif_out_r, tx_irq_r, rx_stb;
	logic [1:0]        rx_kind;
	logic [27:0]       rx_word;
	int                n_errors, num_checks, cycles;

	spdif_transmit_regs i_spdif_transmit_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .spdif_out_r(spdif_out_r), .tx_irq_r(tx_irq_r));
	spdif_line_receiver i_spdif_line_receiver (.pclk(pclk), .presetn(presetn),
		.line(spdif_out_r), .rx_stb(rx_stb), .rx_kind(rx_kind), .rx_word(rx_word));

	always #4 pclk = ~pclk;

	// ------------------------------------------------------------
	// bus and receiver tasks
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {16'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		`CHK(n < 20, 1'b1)
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
		logic [31:0] d;
		logic        e;
		apb(1'b1, idx, wd, d, e);
	endtask : wr

	task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic eerr);
		logic [31:0] d;
		logic        e;
		apb(1'b0, idx, 16'h0, d, e);
		`CHK(d, exp)
		`CHK(e, eerr)
	endtask : rd_chk

	task automatic wait_sub(output logic [1:0] k, output logic [27:0] w);
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (rx_stb !== 1'b1 && n < 300);
		k = rx_kind;
		w = rx_word;
		`CHK(n < 300, 1'b1)
	endtask : wait_sub

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic        e;
		rd_chk(IDX_CS_WORD0, 32'h0, 1'b0);
		rd_chk(IDX_CS_WORD1, 32'h0, 1'b0);
		rd_chk(IDX_CS_WORD2, 32'h0, 1'b0);
		rd_chk(IDX_TX_CONFIG, 32'h40, 1'b0);
		wr(IDX_CS_WORD0, 16'hffff);
		rd_chk(IDX_CS_WORD0, 32'hffff, 1'b0);
		wr(IDX_CS_WORD1, 16'hffff);
		rd_chk(IDX_CS_WORD1, 32'h3fff, 1'b0);
		wr(IDX_CS_WORD2, 16'hefff);
		rd_chk(IDX_CS_WORD2, 32'h0fff, 1'b0);
		wr(IDX_TX_CONFIG, 16'hfffe);
		rd_chk(IDX_TX_CONFIG, 32'hfffe, 1'b0);
		rd_chk(IDX_LEFT_HIGH, 32'h0, 1'b0);
		rd_chk(16'hfd00, 32'h0, 1'b1);
		apb(1'b1, 16'hfd0f, 16'h1234, d, e);
		`CHK(e, 1'b1)
		wr(IDX_CS_WORD2, 16'h0000);
		$display("test regs done");
	endtask : t_regs

	task automatic t_stream();
		logic [1:0]  k;
		logic [27:0] w;
		logic        c;
		wr(IDX_CS_WORD0, 16'hc3a6);
		wr(IDX_CS_WORD1, 16'hf5c3);
		wr(IDX_LEFT_LOW, 16'h0031);
		wr(IDX_LEFT_HIGH, 16'h9a7c);
		// 16-bit right sample, low byte zero
		wr(IDX_RIGHT_LOW, 16'h0000);
		wr(IDX_RIGHT_HIGH, 16'h5e2b);
		wr(IDX_TX_CONFIG, 16'h0005);
		// right stream is linear pcm, validity clear
		wr(IDX_CS_WORD2, 16'h19a5);
		k = 2'h3;
		for (int n = 0; n < 400 && k !== 2'h0; n++)
			wait_sub(k, w);
		for (int f = 0; f < 41; f++)
		begin
			if (f > 0)
				wait_sub(k, w);
			c = (f < 40) ? CSV[f] : 1'b0;
			`CHK(k, (f == 0) ? 2'h0 : 2'h1)
			// first frame after enable carries zero samples
			`CHK(w[26:0], {c, 1'b0, 1'b1, ((f == 0) ? 24'h000000 : LS)})
			`CHK(^w, 1'b0)
			wait_sub(k, w);
			`CHK(k, 2'h2)
			`CHK(w[26:0], {c, 1'b1, 1'b0, ((f == 0) ? 24'h000000 : RS)})
			`CHK(^w, 1'b0)
		end
		$display("test stream done");
	endtask : t_stream

	task automatic t_request();
		logic [1:0]  k;
		logic [27:0] w;
		logic [31:0] d;
		logic        e;
		int          n;
		k = 2'h3;
		for (n = 0; n < 4 && k !== 2'h2; n++)
			wait_sub(k, w);
		apb(1'b0, IDX_CS_WORD2, 16'h0, d, e);
		`CHK(d[CS2_NEW_WORD_BIT], 1'b1)
		`CHK(tx_irq_r, 1'b0)
		wr(IDX_LEFT_HIGH, 16'h9a7c);
		apb(1'b0, IDX_CS_WORD2, 16'h0, d, e);
		`CHK(d[CS2_NEW_WORD_BIT], 1'b0)
		wr(IDX_TX_CONFIG, 16'h0007);
		for (n = 0; n < 300 && tx_irq_r !== 1'b1; n++)
			@(posedge pclk);
		`CHK(tx_irq_r, 1'b1)
		wr(IDX_LEFT_HIGH, 16'h9a7c);
		@(posedge pclk);
		`CHK(tx_irq_r, 1'b0)
		$display("test request done");
	endtask : t_request

	task automatic t_idle();
		logic [1:0]  k;
		logic [27:0] w;
		wr(IDX_TX_CONFIG, 16'h0004);
		repeat (5) wait_sub(k, w);
		if (k !== 2'h2)
			wait_sub(k, w);
		`CHK(w[23:0], 24'h0)
		`CHK(w[25], 1'b1)
		`CHK(^w, 1'b0)
		$display("test idle done");
	endtask : t_idle

	task automatic t_div();
		logic prev;
		int   ones, run, minr, bad, started;
		ones = 0;
		wr(IDX_CS_WORD2, 16'h09a5);
		repeat (200)
		begin
			@(posedge pclk);
			if (spdif_out_r !== 1'b0)
				ones++;
		end
		`CHK(ones, 0)
		wr(IDX_TX_CONFIG, 16'h000d);
		wr(IDX_CS_WORD2, 16'h19a5);
		run = 0;
		minr = 99;
		bad = 0;
		started = 0;
		prev = spdif_out_r;
		// the first run is partial, so only whole half-cells are measured
		repeat (600)
		begin
			@(posedge pclk);
			run++;
			if (spdif_out_r !== prev)
			begin
				if (started != 0 && run % 3 != 0)
					bad++;
				if (started != 0 && run < minr)
					minr = run;
				started = 1;
				run = 0;
				prev = spdif_out_r;
			end
		end
		`CHK(bad, 0)
		`CHK(minr, 3)
		$display("test divider done");
	endtask : t_div

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			close_out();
		end
	end

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_stream();
		t_request();
		t_idle();
		t_div();
		close_out();
	end
endmodule : test_spdif_transmit_regs
